// *** logic/psct_regs.sv ***
// Summary of operation
// - acknowledge command clears status and acquisition error registers after transfers end
// - command bits self-clear when their action finishes; writing zero does nothing
// - fifo clear command empties the pressure fifo after transfers end
// - register reset command restores the debounce and threshold registers once, at sequence end
// - firmware verify command starts one verification after the sequence ends
// - pressure cell self-test command starts one test after the sequence ends
// - converter self-test command starts one test after the sequence ends
// - 8-bit debounce threshold sets count to accept a change, usable 0 to 254
// - debounce value 255 written by host becomes 254 after transfers end
// - fixed flag raised when enabled and pressure stays above 16-bit fixed threshold
// - pressure increasing only if sample beats previous by minimum increase count
// - relative flag raised when enabled and increase stays above 16-bit relative threshold
// - setting fixed or relative flag sets summary flag and pulses interrupt pin
`timescale 1ns/1ps
`default_nettype none
`include "psct_params.svh"
module psct_regs (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic spi_sclk_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_mosi_i,
   output logic spi_miso_o,
   output logic spi_miso_oe_o,
   input wire psct_pkg::psct_sample_s sample_i,
   input wire logic fixed_detect_enable_i,
   input wire logic relative_detect_enable_i,
   input wire logic [7:0] acq_error_set_i,
   input wire logic [2:0] test_done_i,
   output logic [2:0] test_start_o,
   output logic fifo_clear_o,
   output logic int_pulse_o,
   output logic fixed_threshold_flag_o,
   output logic relative_threshold_flag_o,
   output logic summary_interrupt_flag_o
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   localparam psct_pkg::psct_cfg_s CFG_RST = '{`PSCT_RST_DEB, `PSCT_RST_FIXH, `PSCT_RST_FIXL,
      `PSCT_RST_MINI, `PSCT_RST_RELH, `PSCT_RST_RELL};
   logic [2:0] sync1_r;
   logic [2:0] sync2_r;
   logic sclk_d_r;
   logic cs_d_r;
   psct_pkg::psct_spi_e state_r, state_nxt;
   logic [2:0] bit_cnt_r, bit_cnt_nxt;
   logic [7:0] shift_r, shift_nxt;
   logic [7:0] tx_r, tx_nxt;
   logic [6:0] addr_r, addr_nxt;
   logic wr_r, wr_nxt;
   logic miso_r, miso_nxt;
   logic miso_oe_r, miso_oe_nxt;
   psct_pkg::psct_cfg_s cfg_r, cfg_nxt;
   logic [7:0] cmd_r, cmd_nxt;
   logic [2:0] busy_r, busy_nxt;
   logic [2:0] start_r, start_nxt;
   logic fifo_clr_r, fifo_clr_nxt;
   logic fix_r, fix_nxt;
   logic rel_r, rel_nxt;
   logic intf_r, intf_nxt;
   logic pulse_r, pulse_nxt;
   logic [7:0] acq_r, acq_nxt;
   logic [15:0] prev_r, prev_nxt;
   logic prev_ok_r, prev_ok_nxt;
   logic [15:0] base_r, base_nxt;
   logic [7:0] cnt_fix_r, cnt_fix_nxt;
   logic [7:0] cnt_rel_r, cnt_rel_nxt;

   // synchronised pins and their edges
   logic sclk_s;
   logic cs_n_s;
   logic mosi_s;
   logic sclk_rise;
   logic sclk_fall;
   logic seq_end;
   logic ack_clr;
   assign sclk_s = sync2_r[0];
   assign cs_n_s = sync2_r[1];
   assign mosi_s = sync2_r[2];
   assign sclk_rise = sclk_s & ~sclk_d_r;
   assign sclk_fall = ~sclk_s & sclk_d_r;
   assign seq_end = cs_n_s & ~cs_d_r;
   assign ack_clr = seq_end & cmd_r[`PSCT_CMD_ACK];

   // ----------------------------------------------------------------
   // register read mux
   // ----------------------------------------------------------------
   function automatic logic [7:0] rd_data(input logic [6:0] a);
      logic [7:0] d;
      d = 8'h00;
      if (a == `PSCT_ADDR_STATUS)
      begin
         d[`PSCT_STAT_INTF] = intf_r;
         d[`PSCT_STAT_REL] = rel_r;
         d[`PSCT_STAT_FIX] = fix_r;
      end
      else if (a == `PSCT_ADDR_ACQERR) d = acq_r;
      else if (a == `PSCT_ADDR_CMD) d = cmd_r;
      else if (a == `PSCT_ADDR_DEB) d = cfg_r.debounce;
      else if (a == `PSCT_ADDR_FIXH) d = cfg_r.fix_hi;
      else if (a == `PSCT_ADDR_FIXL) d = cfg_r.fix_lo;
      else if (a == `PSCT_ADDR_MINI) d = cfg_r.min_inc;
      else if (a == `PSCT_ADDR_RELH) d = cfg_r.rel_hi;
      else if (a == `PSCT_ADDR_RELL) d = cfg_r.rel_lo;
      return d;
   endfunction : rd_data

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      logic [7:0] byte_in;
      logic do_wr;
      logic [16:0] step;
      logic incr;
      logic [15:0] rise_amt;
      logic fix_cond;
      logic rel_cond;
      logic set_fix;
      logic set_rel;
      byte_in = {shift_r[6:0], mosi_s};
      do_wr = 1'b0;
      step = 17'h0_0000;
      incr = 1'b0;
      rise_amt = 16'h0000;
      fix_cond = 1'b0;
      rel_cond = 1'b0;
      set_fix = 1'b0;
      set_rel = 1'b0;
      state_nxt = state_r;
      bit_cnt_nxt = bit_cnt_r;
      shift_nxt = shift_r;
      tx_nxt = tx_r;
      addr_nxt = addr_r;
      wr_nxt = wr_r;
      miso_nxt = miso_r;
      miso_oe_nxt = miso_oe_r;
      cfg_nxt = cfg_r;
      cmd_nxt = cmd_r;
      busy_nxt = busy_r;
      start_nxt = 3'b000;
      fifo_clr_nxt = 1'b0;
      pulse_nxt = 1'b0;
      prev_nxt = prev_r;
      prev_ok_nxt = prev_ok_r;
      base_nxt = base_r;
      cnt_fix_nxt = cnt_fix_r;
      cnt_rel_nxt = cnt_rel_r;

      // spi client: header byte (write flag, address) then data bytes
      case (state_r)
         psct_pkg::PSCT_IDLE:
         begin
            miso_oe_nxt = 1'b0;
            if (!cs_n_s)
            begin
               state_nxt = psct_pkg::PSCT_HDR;
               bit_cnt_nxt = 3'd0;
               tx_nxt = 8'h00;
               miso_nxt = 1'b0;
               miso_oe_nxt = 1'b1;
            end
         end
         psct_pkg::PSCT_HDR, psct_pkg::PSCT_DATA:
         begin
            if (cs_n_s)
            begin
               state_nxt = psct_pkg::PSCT_IDLE;
               miso_oe_nxt = 1'b0;
            end
            else if (sclk_rise)
            begin
               shift_nxt = byte_in;
               bit_cnt_nxt = bit_cnt_r + 3'd1;
               if (bit_cnt_r == 3'd7)
               begin
                  if (state_r == psct_pkg::PSCT_HDR)
                  begin
                     addr_nxt = byte_in[6:0];
                     wr_nxt = byte_in[7];
                     tx_nxt = rd_data(byte_in[6:0]);
                     state_nxt = psct_pkg::PSCT_DATA;
                  end
                  else
                  begin
                     do_wr = wr_r;
                     addr_nxt = addr_r + 7'd1;
                     tx_nxt = rd_data(addr_r + 7'd1);
                  end
               end
            end
            else if (sclk_fall)
            begin
               miso_nxt = tx_r[7];
               tx_nxt = {tx_r[6:0], 1'b0};
            end
         end
         default:
         begin
            state_nxt = psct_pkg::PSCT_IDLE;
            miso_oe_nxt = 1'b0;
         end
      endcase

      // finished tests release their request bits
      for (int i = 0; i < 3; i++)
      begin
         if (busy_r[i] && test_done_i[i])
         begin
            busy_nxt[i] = 1'b0;
            cmd_nxt[i] = 1'b0;
         end
      end

      // one-time actions once the chip select has risen
      if (seq_end)
      begin
         if (cmd_r[`PSCT_CMD_ACK])
            cmd_nxt[`PSCT_CMD_ACK] = 1'b0;
         if (cmd_r[`PSCT_CMD_FIFO])
         begin
            fifo_clr_nxt = 1'b1;
            cmd_nxt[`PSCT_CMD_FIFO] = 1'b0;
         end
         if (cmd_r[`PSCT_CMD_RST])
         begin
            cfg_nxt = CFG_RST;
            cmd_nxt[`PSCT_CMD_RST] = 1'b0;
         end
         else if (cfg_r.debounce == `PSCT_DEB_BAD)
            cfg_nxt.debounce = `PSCT_DEB_MAX;
         for (int i = 0; i < 3; i++)
         begin
            if (cmd_r[i] && !busy_r[i])
            begin
               start_nxt[i] = 1'b1;
               busy_nxt[i] = 1'b1;
            end
         end
      end

      // host writes: command bits only set, reserved bits dropped
      if (do_wr)
      begin
         if (addr_r == `PSCT_ADDR_CMD)
            cmd_nxt = cmd_nxt | (byte_in & `PSCT_CMD_WMASK);
         else if (addr_r == `PSCT_ADDR_DEB) cfg_nxt.debounce = byte_in;
         else if (addr_r == `PSCT_ADDR_FIXH) cfg_nxt.fix_hi = byte_in;
         else if (addr_r == `PSCT_ADDR_FIXL) cfg_nxt.fix_lo = byte_in;
         else if (addr_r == `PSCT_ADDR_MINI) cfg_nxt.min_inc = byte_in;
         else if (addr_r == `PSCT_ADDR_RELH) cfg_nxt.rel_hi = byte_in;
         else if (addr_r == `PSCT_ADDR_RELL) cfg_nxt.rel_lo = byte_in;
      end

      // pressure change detection per sample
      if (sample_i.valid)
      begin
         step = {1'b0, prev_r} + {9'h000, cfg_r.min_inc};
         incr = prev_ok_r && ({1'b0, sample_i.value} >= step);
         base_nxt = incr ? base_r : sample_i.value;
         rise_amt = sample_i.value - base_r;
         fix_cond = fixed_detect_enable_i
            && (sample_i.value > {cfg_r.fix_hi, cfg_r.fix_lo});
         rel_cond = relative_detect_enable_i && incr
            && (rise_amt > {cfg_r.rel_hi, cfg_r.rel_lo});
         cnt_fix_nxt = !fix_cond ? 8'h00
            : (cnt_fix_r == 8'hff) ? cnt_fix_r : cnt_fix_r + 8'h01;
         cnt_rel_nxt = !rel_cond ? 8'h00
            : (cnt_rel_r == 8'hff) ? cnt_rel_r : cnt_rel_r + 8'h01;
         set_fix = fix_cond
            && ({1'b0, cnt_fix_r} + 9'h001 >= {1'b0, cfg_r.debounce});
         set_rel = rel_cond
            && ({1'b0, cnt_rel_r} + 9'h001 >= {1'b0, cfg_r.debounce});
         prev_nxt = sample_i.value;
         prev_ok_nxt = 1'b1;
      end

      // sticky flags: a set in the clearing cycle wins
      fix_nxt = (fix_r & ~ack_clr) | set_fix;
      rel_nxt = (rel_r & ~ack_clr) | set_rel;
      intf_nxt = (intf_r & ~ack_clr) | set_fix | set_rel;
      pulse_nxt = set_fix | set_rel;
      acq_nxt = (acq_r & ~{8{ack_clr}}) | acq_error_set_i;
   end

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         sync1_r <= 3'b010;
         sync2_r <= 3'b010;
         sclk_d_r <= 1'b0;
         cs_d_r <= 1'b1;
      end
      else
      begin
         sync1_r <= {spi_mosi_i, spi_cs_n_i, spi_sclk_i};
         sync2_r <= sync1_r;
         sclk_d_r <= sync2_r[0];
         cs_d_r <= sync2_r[1];
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_r <= psct_pkg::PSCT_IDLE;
         bit_cnt_r <= 3'd0;
         shift_r <= 8'h00;
         tx_r <= 8'h00;
         addr_r <= 7'h00;
         wr_r <= 1'b0;
         miso_r <= 1'b0;
         miso_oe_r <= 1'b0;
         cfg_r <= CFG_RST;
         cmd_r <= `PSCT_RST_CMD;
         busy_r <= 3'b000;
         start_r <= 3'b000;
         fifo_clr_r <= 1'b0;
         fix_r <= 1'b0;
         rel_r <= 1'b0;
         intf_r <= 1'b0;
         pulse_r <= 1'b0;
         acq_r <= 8'h00;
         prev_r <= 16'h0000;
         prev_ok_r <= 1'b0;
         base_r <= 16'h0000;
         cnt_fix_r <= 8'h00;
         cnt_rel_r <= 8'h00;
      end
      else
      begin
         state_r <= state_nxt;
         bit_cnt_r <= bit_cnt_nxt;
         shift_r <= shift_nxt;
         tx_r <= tx_nxt;
         addr_r <= addr_nxt;
         wr_r <= wr_nxt;
         miso_r <= miso_nxt;
         miso_oe_r <= miso_oe_nxt;
         cfg_r <= cfg_nxt;
         cmd_r <= cmd_nxt;
         busy_r <= busy_nxt;
         start_r <= start_nxt;
         fifo_clr_r <= fifo_clr_nxt;
         fix_r <= fix_nxt;
         rel_r <= rel_nxt;
         intf_r <= intf_nxt;
         pulse_r <= pulse_nxt;
         acq_r <= acq_nxt;
         prev_r <= prev_nxt;
         prev_ok_r <= prev_ok_nxt;
         base_r <= base_nxt;
         cnt_fix_r <= cnt_fix_nxt;
         cnt_rel_r <= cnt_rel_nxt;
      end
   end

   // outputs straight from flops
   assign spi_miso_o = miso_r;
   assign spi_miso_oe_o = miso_oe_r;
   assign test_start_o = start_r;
   assign fifo_clear_o = fifo_clr_r;
   assign int_pulse_o = pulse_r;
   assign fixed_threshold_flag_o = fix_r;
   assign relative_threshold_flag_o = rel_r;
   assign summary_interrupt_flag_o = intf_r;
endmodule : psct_regs
`default_nettype wire

// *** logic/psct_params.svh ***
`ifndef PSCT_PARAMS_SVH
`define PSCT_PARAMS_SVH
// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define PSCT_ADDR_STATUS 7'h55
`define PSCT_ADDR_ACQERR 7'h56
`define PSCT_ADDR_CMD 7'h57
`define PSCT_ADDR_DEB 7'h58
`define PSCT_ADDR_FIXH 7'h59
`define PSCT_ADDR_FIXL 7'h5a
`define PSCT_ADDR_MINI 7'h5b
`define PSCT_ADDR_RELH 7'h5c
`define PSCT_ADDR_RELL 7'h5d
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PSCT_RST_CMD 8'h00
`define PSCT_RST_DEB 8'h05
`define PSCT_RST_FIXH 8'h03
`define PSCT_RST_FIXL 8'h20
`define PSCT_RST_MINI 8'h03
`define PSCT_RST_RELH 8'h00
`define PSCT_RST_RELL 8'h32
// ----------------------------------------------------------------
// field positions and limits
// ----------------------------------------------------------------
`define PSCT_CMD_ACK 7
`define PSCT_CMD_FIFO 4
`define PSCT_CMD_RST 3
`define PSCT_CMD_FV 2
`define PSCT_CMD_PST 1
`define PSCT_CMD_ADC 0
`define PSCT_CMD_WMASK 8'h9f
`define PSCT_STAT_INTF 7
`define PSCT_STAT_REL 5
`define PSCT_STAT_FIX 4
`define PSCT_DEB_MAX 8'hfe
`define PSCT_DEB_BAD 8'hff
`endif

// *** logic/psct_pkg.sv ***
`default_nettype none
package psct_pkg;
   // ----------------------------------------------------------------
   // threshold registers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] debounce;
      logic [7:0] fix_hi;
      logic [7:0] fix_lo;
      logic [7:0] min_inc;
      logic [7:0] rel_hi;
      logic [7:0] rel_lo;
   } psct_cfg_s;

   // pressure sample from the acquisition path
   typedef struct packed {
      logic valid;
      logic [15:0] value;
   } psct_sample_s;

   // spi client sequencer states
   typedef enum logic [2:0] {
      PSCT_IDLE = 3'b001,
      PSCT_HDR = 3'b010,
      PSCT_DATA = 3'b100
   } psct_spi_e;
endpackage : psct_pkg
`default_nettype wire

// *** sim/psct_regs_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module psct_regs_checker (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic spi_cs_n_i,
   input wire psct_pkg::psct_sample_s sample_i,
   input wire logic fixed_detect_enable_i,
   input wire logic relative_detect_enable_i,
   input wire logic [2:0] test_start_o,
   input wire logic fifo_clear_o,
   input wire logic int_pulse_o,
   input wire logic fixed_threshold_flag_o,
   input wire logic relative_threshold_flag_o,
   input wire logic summary_interrupt_flag_o
);
   // ----------------------------------------------------------------
   // command and detection output checks
   // ----------------------------------------------------------------
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   property p_int_flag;
      int_pulse_o |-> fixed_threshold_flag_o || relative_threshold_flag_o;
   endproperty
   a_int_flag: assert property (p_int_flag)
      else $error("interrupt pulse with no flag");
   property p_rise_int;
      $rose(fixed_threshold_flag_o) || $rose(relative_threshold_flag_o)
         |-> int_pulse_o && summary_interrupt_flag_o;
   endproperty
   a_rise_int: assert property (p_rise_int)
      else $error("flag set without summary or pulse");
   property p_fifo_end;
      fifo_clear_o |-> spi_cs_n_i && $past(spi_cs_n_i, 2);
   endproperty
   a_fifo_end: assert property (p_fifo_end)
      else $error("fifo clear before sequence end");
   property p_start_end;
      |test_start_o |-> spi_cs_n_i && $past(spi_cs_n_i, 2);
   endproperty
   a_start_end: assert property (p_start_end)
      else $error("test start before sequence end");
   property p_one_shot;
      !(fifo_clear_o && $past(fifo_clear_o)) && !(|(test_start_o & $past(test_start_o)));
   endproperty
   a_one_shot: assert property (p_one_shot)
      else $error("action pulse longer than one cycle");
   property p_fall_end;
      $fell(fixed_threshold_flag_o) || $fell(relative_threshold_flag_o)
         || $fell(summary_interrupt_flag_o) |-> spi_cs_n_i && $past(spi_cs_n_i, 2);
   endproperty
   a_fall_end: assert property (p_fall_end)
      else $error("flag cleared outside sequence end");
   property p_fix_src;
      $rose(fixed_threshold_flag_o) |-> $past(sample_i.valid && fixed_detect_enable_i);
   endproperty
   a_fix_src: assert property (p_fix_src)
      else $error("fixed flag without enabled sample");
   property p_rel_src;
      $rose(relative_threshold_flag_o) |-> $past(sample_i.valid && relative_detect_enable_i);
   endproperty
   a_rel_src: assert property (p_rel_src)
      else $error("relative flag without enabled sample");
endmodule : psct_regs_checker
`default_nettype wire

// *** sim/psct_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module psct_host_model (
   output logic sclk_o,
   output logic cs_n_o,
   output logic mosi_o,
   input wire logic miso_i
);
   // ----------------------------------------------------------------
   // spi controller, mode 0, clock parked low between frames
   // ----------------------------------------------------------------
   initial
   begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
   end
   // select off the core clock phase
   task automatic open_f;
      #3 cs_n_o = 1'b0;
      #80;
   endtask : open_f
   // one byte msb first, capture on the rising edge
   task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--)
      begin
         mosi_o = tx[i];
         #80 sclk_o = 1'b1;
         rx[i] = miso_i;
         #80 sclk_o = 1'b0;
      end
   endtask : xb
   // end of sequence; requested actions run after this
   task automatic close_f;
      #80 cs_n_o = 1'b1;
      mosi_o = ~mosi_o; // released line flips its last bit
      #400;
   endtask : close_f
endmodule : psct_host_model
`default_nettype wire

// *** sim/psct_regs_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module psct_regs_bench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic sclk, cs_n, mosi, miso, miso_oe, fclr, intp, ffix, frel, fsum;
   psct_pkg::psct_sample_s smp = '0;
   logic fen = 1'b0;
   logic ren = 1'b0;
   logic [7:0] aerr = 8'h00;
   logic [2:0] tdone = 3'b000;
   logic [2:0] tstart;
   logic [7:0] d;
   int mismatches = 0;
   int n_checks = 0;
   int n_fclr = 0;
   int n_int = 0;
   int n_st = 0;
   int n0;
   localparam logic [7:0] RV [7] = '{8'h00, 8'h05, 8'h03, 8'h20, 8'h03, 8'h00, 8'h32};
   always #4 clk = ~clk;
   psct_regs u_psct_regs (.core_clk_i(clk), .rst_i(rst), .spi_sclk_i(sclk),
      .spi_cs_n_i(cs_n), .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(miso_oe),
      .sample_i(smp), .fixed_detect_enable_i(fen), .relative_detect_enable_i(ren),
      .acq_error_set_i(aerr), .test_done_i(tdone), .test_start_o(tstart),
      .fifo_clear_o(fclr), .int_pulse_o(intp), .fixed_threshold_flag_o(ffix),
      .relative_threshold_flag_o(frel), .summary_interrupt_flag_o(fsum));
   psct_host_model u_psct_host_model (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi),
      .miso_i(miso));
   // count action pulses
   always @(posedge clk)
   begin
      n_fclr <= n_fclr + int'(fclr);
      n_int <= n_int + int'(intp);
      n_st <= n_st + $countones(tstart);
   end
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [6:0] a, input logic [7:0] v);
      logic [7:0] r;
      u_psct_host_model.open_f();
      u_psct_host_model.xb({1'b1, a}, r);
      u_psct_host_model.xb(v, r);
      u_psct_host_model.close_f();
   endtask : wr
   task automatic rd(input logic [6:0] a, output logic [7:0] v);
      logic [7:0] r;
      u_psct_host_model.open_f();
      chk(8'(miso_oe), 8'h01); // data line driven while selected
      u_psct_host_model.xb({1'b0, a}, r);
      u_psct_host_model.xb(8'h00, v);
      u_psct_host_model.close_f();
      chk(8'(miso_oe), 8'h00); // data line released after the sequence
   endtask : rd
   task automatic sp(input logic [15:0] v);
      @(posedge clk) smp <= '{1'b1, v};
      @(posedge clk) smp.valid <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : sp
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset_vals;
      for (int i = 0; i < 7; i++)
      begin
         rd(7'h57 + 7'(i), d);
         chk(d, RV[i]);
      end
   endtask : t_reset_vals
   task automatic t_cmd;
      wr(7'h57, 8'h60);
      rd(7'h57, d);
      chk(d, 8'h00);
      n0 = n_fclr;
      wr(7'h57, 8'h10);
      chk(8'(n_fclr - n0), 8'h01);
      rd(7'h57, d);
      chk(d, 8'h00);
      n0 = n_st;
      wr(7'h57, 8'h07);
      chk(8'(n_st - n0), 8'h03);
      rd(7'h57, d);
      chk(d, 8'h07);
      // a zero write leaves pending requests alone and starts nothing new
      wr(7'h57, 8'h00);
      rd(7'h57, d);
      chk(d, 8'h07);
      chk(8'(n_st - n0), 8'h03);
      @(posedge clk) tdone <= 3'b111;
      @(posedge clk) tdone <= 3'b000;
      rd(7'h57, d);
      chk(d, 8'h00);
   endtask : t_cmd
   task automatic t_thr;
      wr(7'h58, 8'hff);
      rd(7'h58, d);
      chk(d, 8'hfe);
      wr(7'h5a, 8'h00);
      rd(7'h59, d);
      chk(d, 8'h03);
      wr(7'h5b, 8'h09);
      wr(7'h57, 8'h08);
      t_reset_vals();
   endtask : t_thr
   task automatic t_fixed;
      wr(7'h58, 8'h03);
      wr(7'h59, 8'h01);
      wr(7'h5a, 8'h00);
      @(posedge clk) fen <= 1'b1;
      n0 = n_int;
      sp(16'h012c);
      sp(16'h012c);
      sp(16'h0100);
      sp(16'h012c);
      sp(16'h012c);
      chk(8'(ffix), 8'h00);
      sp(16'h012c);
      chk(8'(ffix), 8'h01);
      chk(8'(fsum), 8'h01);
      chk(8'(n_int - n0), 8'h01);
      fen <= 1'b0;
      @(posedge clk) aerr <= 8'h81;
      @(posedge clk) aerr <= 8'h00;
      rd(7'h56, d);
      chk(d, 8'h81);
      rd(7'h55, d);
      chk(d, 8'h90);
      wr(7'h57, 8'h80);
      chk(8'({ffix, fsum}), 8'h00);
      rd(7'h56, d);
      chk(d, 8'h00);
   endtask : t_fixed
   task automatic t_rel;
      wr(7'h58, 8'h01);
      wr(7'h5d, 8'h05);
      // first sample, sent with detection off, counts as an increase as it is far above the last one; the next restarts the history
      sp(16'h03e8);
      @(posedge clk) ren <= 1'b1;
      sp(16'h03ea);
      sp(16'h03ec);
      sp(16'h03ef);
      chk(8'(frel), 8'h00);
      sp(16'h03f2);
      chk(8'(frel), 8'h01);
   endtask : t_rel
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : final_report
   initial
   begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      t_reset_vals();
      t_cmd();
      t_thr();
      t_fixed();
      t_rel();
      final_report();
   end
   // hang guard, about four times the expected run
   initial
   begin
      #500_000;
      mismatches++;
      final_report();
   end
endmodule : psct_regs_bench
bind psct_regs psct_regs_checker u_psct_regs_checker (.core_clk_i(core_clk_i), .rst_i(rst_i),
   .spi_cs_n_i(spi_cs_n_i), .sample_i(sample_i), .fixed_detect_enable_i(fixed_detect_enable_i),
   .relative_detect_enable_i(relative_detect_enable_i), .test_start_o(test_start_o),
   .fifo_clear_o(fifo_clear_o), .int_pulse_o(int_pulse_o),
   .fixed_threshold_flag_o(fixed_threshold_flag_o),
   .relative_threshold_flag_o(relative_threshold_flag_o),
   .summary_interrupt_flag_o(summary_interrupt_flag_o));
`default_nettype wire
